// *** src/bsr_regs.sv ***
/*
  Register slice of a backlight driver: identity, forced full duty per
  channel, latched die thermal reading, and NVM controller status.
  Assumes a serial front end that presents one-cycle read and write
  strobes, and an NVM engine that reports its own completion.
*/
`timescale 1ns/1ps
module bsr_regs #(
  parameter int NVM_CYCLES = bsr_pkg::NVM_OP_CYCLES,
  parameter logic [7:0] IDENT_VALUE = 8'h5a // Arbitrary neutral identity
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire bsr_pkg::bsr_req_t req_i,
  input wire logic [10:0] therm_i,
  input wire logic [5:0] pwm_i,
  input wire logic nvm_done_i,
  output logic [7:0] rdata_o,
  output logic [5:0] led_o,
  output logic nvm_burn_o,
  output logic nvm_load_o
);
  localparam int CW = $clog2(NVM_CYCLES + 1);

  logic [5:0] full_duty;
  logic [2:0] nvm_ctrl;
  logic [10:0] therm_cap;
  logic busy;
  logic [CW-1:0] op_cnt;

  bsr_pkg::bsr_ident_t ident;
  assign ident = bsr_pkg::bsr_ident_t'(IDENT_VALUE);

  // One comparator shape for every register select
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction : addr_is

  wire hit_ident = addr_is(req_i.addr, bsr_pkg::OFS_IDENTITY);
  wire hit_duty = addr_is(req_i.addr, bsr_pkg::OFS_FULL_DUTY);
  wire hit_nvm = addr_is(req_i.addr, bsr_pkg::OFS_NVM_CTRL);
  wire hit_upper = addr_is(req_i.addr, bsr_pkg::OFS_THERM_UPPER);
  wire hit_lower = addr_is(req_i.addr, bsr_pkg::OFS_THERM_LOWER);
  wire wr_duty = req_i.wr && hit_duty;
  wire wr_nvm = req_i.wr && hit_nvm;
  wire rd_ident = req_i.rd && hit_ident;
  wire rd_duty = req_i.rd && hit_duty;
  wire rd_upper = req_i.rd && hit_upper;
  wire rd_lower = req_i.rd && hit_lower;
  wire rd_nvm = req_i.rd && hit_nvm;
  // Start only on a rising burn/load with unlock already held
  wire unlocked = nvm_ctrl[bsr_pkg::BIT_UNLOCK];
  wire start_burn = wr_nvm && unlocked && !busy && req_i.wdata[bsr_pkg::BIT_BURN]
                    && !nvm_ctrl[bsr_pkg::BIT_BURN];
  wire start_load = wr_nvm && unlocked && !busy && req_i.wdata[bsr_pkg::BIT_LOAD]
                    && !nvm_ctrl[bsr_pkg::BIT_LOAD];
  wire op_end = busy && (nvm_done_i || op_cnt == CW'(1));

  // Upper read returns live bits while latching all eleven
  logic [7:0] next_rdata;
  always_comb begin
    case (req_i.addr)
      bsr_pkg::OFS_IDENTITY: next_rdata = ident;
      bsr_pkg::OFS_FULL_DUTY: next_rdata = {2'h0, full_duty};
      bsr_pkg::OFS_THERM_UPPER: next_rdata = therm_i[10:3];
      bsr_pkg::OFS_THERM_LOWER: next_rdata = {therm_cap[2:0], 5'h00};
      bsr_pkg::OFS_NVM_CTRL: next_rdata = {!busy, 4'h0, nvm_ctrl};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      full_duty <= bsr_pkg::RST_FULL_DUTY[5:0];
      nvm_ctrl <= bsr_pkg::RST_NVM_CTRL[2:0];
      therm_cap <= bsr_pkg::RST_THERM;
      rdata_o <= 8'h00;
    end else begin
      if (wr_duty) full_duty <= req_i.wdata[5:0];
      if (wr_nvm) nvm_ctrl <= req_i.wdata[2:0];
      if (rd_upper) therm_cap <= therm_i;
      if (req_i.rd) rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      busy <= 1'b0;
      op_cnt <= '0;
      nvm_burn_o <= 1'b0;
      nvm_load_o <= 1'b0;
    end else begin
      nvm_burn_o <= start_burn;
      nvm_load_o <= start_load && !start_burn;
      if (start_burn || start_load) begin
        busy <= 1'b1;
        op_cnt <= CW'(NVM_CYCLES);
      end else if (op_end) begin
        busy <= 1'b0;
        op_cnt <= '0;
      end else if (busy) begin
        op_cnt <= op_cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) led_o <= 6'h00;
    else led_o <= pwm_i | full_duty;
  end

  // Busy length counter; a repetition this long would not unroll
  logic [CW-1:0] busy_len;
  always_ff @(posedge mclk_i) begin
    if (srst_i || !busy) busy_len <= '0;
    else busy_len <= busy_len + CW'(1);
  end

  sequence s_upper_then_lower;
    rd_upper ##1 ((!rd_upper) throughout (##[0:7] rd_lower));
  endsequence

  // Only reads that fall surely inside the busy span are judged
  sequence s_op_running;
    (start_burn || start_load) && (NVM_CYCLES >= 8)
    ##1 ((!nvm_done_i) throughout (##[0:7] rd_nvm));
  endsequence

  sequence s_op_finished;
    op_end ##1 ((!(start_burn || start_load)) throughout (##[0:7] rd_nvm));
  endsequence

  // Identity and full duty mask
  a_ident_const: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    rd_ident |=> rdata_o == IDENT_VALUE)
    else $error("identity read wrong");

  a_ident_nowrite: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    req_i.wr && hit_ident && !req_i.rd |=> $stable(rdata_o))
    else $error("identity write had an effect");

  a_duty_write: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    wr_duty |=> full_duty == $past(req_i.wdata[5:0]))
    else $error("mask write not stored");

  a_duty_hold: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    !wr_duty |=> $stable(full_duty))
    else $error("mask changed without write");

  a_duty_pwm: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    1'b1 |=> (led_o & ~$past(full_duty)) == ($past(pwm_i) & ~$past(full_duty)))
    else $error("cleared channel not under pwm");

  a_duty_force: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    full_duty[0] |=> led_o[0])
    else $error("forced channel not on");

  a_force_all: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    1'b1 |=> (led_o | ~$past(full_duty)) == 6'h3f)
    else $error("a forced channel is off");

  // Thermal reading and its capture
  a_upper_bits: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    rd_upper |=> rdata_o == $past(therm_i[10:3]))
    else $error("upper thermal byte wrong");

  a_lower_match: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    s_upper_then_lower |=> rdata_o[7:5] == $past(therm_cap[2:0]))
    else $error("lower thermal byte not from capture");

  a_lower_zero: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    rd_lower |=> rdata_o[4:0] == 5'h00)
    else $error("unused lower thermal bits nonzero");

  a_capture_take: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    rd_upper |=> therm_cap == $past(therm_i))
    else $error("upper read did not capture reading");

  a_capture_hold: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    !rd_upper |=> $stable(therm_cap))
    else $error("capture changed without upper read");

  // Memory controller status and strobes, and reset values
  a_idle_busy: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    s_op_running |=> !rdata_o[7])
    else $error("idle flag set while busy");

  a_idle_ready: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    s_op_finished |=> rdata_o[7])
    else $error("idle flag clear after operation");

  a_idle_reset: assert property (
    @(posedge mclk_i)
    srst_i ##1 (!srst_i && rd_nvm) |=> rdata_o[7])
    else $error("idle flag clear after reset");

  a_busy_early: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    busy && nvm_done_i |=> !busy)
    else $error("early completion ignored");

  a_reset_zero: assert property (
    @(posedge mclk_i)
    srst_i |=> full_duty == 6'h00 && nvm_ctrl == 3'h0)
    else $error("reset values wrong");

  a_reset_outputs: assert property (
    @(posedge mclk_i)
    srst_i |=> rdata_o == 8'h00 && led_o == 6'h00 && !nvm_burn_o && !nvm_load_o)
    else $error("outputs not cleared by reset");

  a_locked_idle: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    wr_nvm && !unlocked && !busy |=> !busy)
    else $error("operation started without unlock");

  a_locked_strobe: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    wr_nvm && !unlocked |=> !nvm_burn_o && !nvm_load_o)
    else $error("strobe without unlock");

  a_load_unlock: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    nvm_load_o |-> $past(unlocked))
    else $error("load strobe while locked");

  a_burn_pulse: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    start_burn |=> nvm_burn_o ##1 !nvm_burn_o)
    else $error("burn strobe wrong");

  a_burn_cause: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    nvm_burn_o |-> $past(wr_nvm && req_i.wdata[bsr_pkg::BIT_BURN]))
    else $error("burn strobe without burn write");

  a_burn_only: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    nvm_burn_o |-> !nvm_load_o)
    else $error("burn and load strobes together");

  a_busy_strobe: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    nvm_burn_o || nvm_load_o |-> busy)
    else $error("strobe without busy");

  a_busy_bounded: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    busy |-> busy_len < CW'(NVM_CYCLES))
    else $error("busy longer than operation time");

  a_load_pulse: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    start_load && !start_burn |=> nvm_load_o)
    else $error("load strobe missing");

  a_load_cause: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    nvm_load_o |-> $past(wr_nvm && req_i.wdata[bsr_pkg::BIT_LOAD]))
    else $error("load strobe without load write");

  // Unused bits and control write
  a_duty_upper: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    rd_duty |=> rdata_o[7:6] == 2'h0)
    else $error("unused duty bits nonzero");

  a_nvm_unused: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    rd_nvm |=> rdata_o[6:3] == 4'h0)
    else $error("unused control bits nonzero");

  a_nvm_write: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    wr_nvm |=> nvm_ctrl == $past(req_i.wdata[2:0]))
    else $error("control bits not stored");
endmodule : bsr_regs

// *** src/bsr_pkg.sv ***
/*
  Package for the backlight status and identity register slice: offsets,
  field positions, reset values, timing constants and carrier structs.
  Assumes an 8-bit register port decoded by the serial front end.
*/
package bsr_pkg;
  localparam logic [7:0] OFS_IDENTITY = 8'h03;
  localparam logic [7:0] OFS_FULL_DUTY = 8'h04;
  localparam logic [7:0] OFS_THERM_UPPER = 8'h05;
  localparam logic [7:0] OFS_THERM_LOWER = 8'h06;
  localparam logic [7:0] OFS_NVM_CTRL = 8'h72;

  localparam logic [7:0] RST_FULL_DUTY = 8'h00;
  localparam logic [7:0] RST_NVM_CTRL = 8'h00;
  localparam logic [10:0] RST_THERM = 11'h000;

  localparam int BIT_IDLE = 7;
  localparam int BIT_UNLOCK = 2;
  localparam int BIT_BURN = 1;
  localparam int BIT_LOAD = 0;
  localparam int NUM_CHANNELS = 6;

  // Burn and load both take about this long
  localparam int NVM_OP_MS = 200;
  localparam int CLK_HZ = 10_000_000;
  localparam int NVM_OP_CYCLES = (NVM_OP_MS * (CLK_HZ / 1000));

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bsr_req_t;

  typedef struct packed {
    logic panel_flag;
    logic [3:0] maker_code_field;
    logic [2:0] revision_code_field;
  } bsr_ident_t;
endpackage : bsr_pkg

// *** bench/bsr_host.sv ***
/*
  Host model: issues one-cycle register requests.
  Assumes the bench calls xfer at a falling edge.
*/
`timescale 1ns/1ps
module bsr_host (
  input wire logic mclk_i,
  output bsr_pkg::bsr_req_t req_o
);
  initial req_o = '0;
  // Released addr and wdata show inverted values, never the last ones; wr and rd drop to zero
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge mclk_i);
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(negedge mclk_i);
  endtask : xfer
endmodule : bsr_host

// *** bench/bsr_regs_tb.sv ***
/*
  Self-checking bench for the register slice.
  Assumes the design keeps its own assertions.
*/
`timescale 1ns/1ps
module bsr_regs_tb;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
  logic mclk_i = 0, srst_i = 1, nvm_done_i = 0, rd1 = 0, rd2 = 0;
  logic [10:0] therm_i = '0;
  logic [5:0] pwm_i = '0, led_o;
  logic [7:0] rdata_o, r;
  logic nvm_burn_o, nvm_load_o;
  bsr_pkg::bsr_req_t req;
  logic [7:0] exp_q[$];
  int errors = 0, checks_done = 0, burns = 0, loads = 0;
  bsr_host i_bsr_host (.mclk_i(mclk_i), .req_o(req));
  bsr_regs #(.NVM_CYCLES(20), .IDENT_VALUE(ID)) i_bsr_regs (.mclk_i(mclk_i),
    .srst_i(srst_i), .req_i(req), .therm_i(therm_i), .pwm_i(pwm_i),
    .nvm_done_i(nvm_done_i), .rdata_o(rdata_o), .led_o(led_o),
    .nvm_burn_o(nvm_burn_o), .nvm_load_o(nvm_load_o));
  initial forever #50 mclk_i = ~mclk_i;
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic test_done;
    $display("Checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // Idle cycle after each read keeps the answer steady when sampled
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_bsr_host.xfer(1'b0, a, 8'h00);
    @(negedge mclk_i);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_bsr_host.xfer(1'b1, a, d);
  endtask : wr
  always @(posedge mclk_i) begin
    rd1 <= req.rd;
    rd2 <= rd1;
    burns <= burns + int'(nvm_burn_o);
    loads <= loads + int'(nvm_load_o);
  end
  always @(negedge mclk_i) if (rd2) cmp("rdata_o", exp_q.pop_front(), rdata_o);
  initial begin
    repeat (5000) @(posedge mclk_i);
    errors++;
    test_done;
  end
  initial begin
    void'($urandom(63));
    repeat (12) @(negedge mclk_i);
    srst_i = 0;
    rd(8'h72, 8'h80);
    rd(8'h04, 8'h00);
    wr(8'h03, 8'hff);
    rd(8'h03, ID);
    rd(8'h40, 8'h00);
    $display("Test reset and identity done");
    r = 8'($urandom) | 8'hc0;
    pwm_i = 6'($urandom);
    wr(8'h04, r);
    rd(8'h04, {2'b00, r[5:0]});
    cmp("led_o", {2'b00, pwm_i | r[5:0]}, {2'b00, led_o});
    $display("Test full duty done");
    therm_i = 11'($urandom);
    r = {therm_i[2:0], 5'h00};
    rd(8'h05, therm_i[10:3]);
    therm_i = ~therm_i;
    rd(8'h06, r);
    $display("Test thermal done");
    wr(8'h72, 8'h02);
    wr(8'h72, 8'h04);
    wr(8'h72, 8'h02);
    rd(8'h72, 8'h02);
    repeat (30) @(negedge mclk_i);
    rd(8'h72, 8'h82);
    wr(8'h72, 8'h7c);
    rd(8'h72, 8'h84);
    wr(8'h72, 8'h01);
    nvm_done_i = 1;
    @(negedge mclk_i);
    nvm_done_i = 0;
    rd(8'h72, 8'h81);
    cmp("burns", 8'h01, 8'(burns));
    cmp("loads", 8'h01, 8'(loads));
    $display("Test nvm control done");
    test_done;
  end
endmodule : bsr_regs_tb
